/* hdl/rxps_top.sv */
// Receive output register, parity, status coding and sync machines for four channels
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module rxps_top (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire logic [rxps_pkg::NCH-1:0]      charStrobe,
  input  wire logic [rxps_pkg::NCH-1:0][7:0] decChar,
  input  wire logic [rxps_pkg::NCH-1:0][9:0] rawChar,
  input  wire logic [rxps_pkg::NCH-1:0]      framingHit,
  input  wire logic [rxps_pkg::NCH-1:0]      specialHit,
  input  wire logic [rxps_pkg::NCH-1:0]      codeViol,
  input  wire logic [rxps_pkg::NCH-1:0]      rdErr,
  input  wire logic [rxps_pkg::NCH-1:0]      bufErr,
  input  wire logic [rxps_pkg::NCH-1:0]      pllUnlock,
  input  wire logic [rxps_pkg::NCH-1:0]      bitSyncLost,
  input  wire logic [rxps_pkg::NCH-1:0]      bondOk,
  input  wire logic [rxps_pkg::NCH-1:0]      bondFail,
  input  wire logic [rxps_pkg::NCH-1:0]      bistActive,
  input  wire logic [rxps_pkg::NCH-1:0][2:0] bistStatus,
  output logic      [rxps_pkg::NCH-1:0][7:0] rx_char_out,
  output logic      [rxps_pkg::NCH-1:0][2:0] rx_status_out,
  output logic      [rxps_pkg::NCH-1:0]      rx_parity_out,
  output logic      [rxps_pkg::NCH-1:0]      rxParityOeN,
  output logic                               irq,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic      [1:0]                    s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic      [31:0]                   s_axi_rdata,
  output logic      [1:0]                    s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);

  // Priority coding of coinciding conditions, highest first
  function automatic logic [2:0] encStatus(input logic loss, input logic buf_e,
                                           input logic typeB, input logic cv,
                                           input logic fr, input logic rd,
                                           input logic sp);
    logic [2:0] s;
    s = rxps_pkg::ST_NORMAL;
    if (loss) begin
      s = rxps_pkg::ST_LOSS_SYNC;
    end else if (buf_e) begin
      s = typeB ? rxps_pkg::ST_LOSS_SYNC : rxps_pkg::ST_BUF_LOCK;
    end else if (cv) begin
      s = rxps_pkg::ST_CODE_VIOL;
    end else if (fr) begin
      s = rxps_pkg::ST_FRAMING;
    end else if (rd) begin
      s = rxps_pkg::ST_RD_ERR;
    end else if (sp) begin
      s = rxps_pkg::ST_SPECIAL;
    end
    return s;
  endfunction : encStatus

  // Odd parity bit over a word
  function automatic logic oddPar(input logic [10:0] w);
    return ~(^w);
  endfunction : oddPar

  // Control and interrupt registers
  logic [4:0]  ctrl_reg;
  logic [4:0]  ctrl_next;
  logic [7:0]  intStat_reg;
  logic [7:0]  intStat_next;
  logic [7:0]  intMask_reg;
  logic [7:0]  intMask_next;
  logic        awHeld_reg;
  logic        awHeld_next;
  logic [7:0]  awAddr_reg;
  logic [7:0]  awAddr_next;
  logic        wHeld_reg;
  logic        wHeld_next;
  logic [31:0] wData_reg;
  logic [31:0] wData_next;
  logic [3:0]  wStrb_reg;
  logic [3:0]  wStrb_next;
  logic        bValid_reg;
  logic        bValid_next;
  logic [1:0]  bResp_reg;
  logic [1:0]  bResp_next;
  logic        rValid_reg;
  logic        rValid_next;
  logic [31:0] rData_reg;
  logic [31:0] rData_next;
  logic [1:0]  rResp_reg;
  logic [1:0]  rResp_next;

  // Channel output stage and sync machines
  rxps_pkg::rxps_sync_t [rxps_pkg::NCH-1:0] sync_reg;
  rxps_pkg::rxps_sync_t [rxps_pkg::NCH-1:0] sync_next;
  logic [rxps_pkg::NCH-1:0][7:0] char_reg;
  logic [rxps_pkg::NCH-1:0][7:0] char_next;
  logic [rxps_pkg::NCH-1:0][2:0] stat_reg;
  logic [rxps_pkg::NCH-1:0][2:0] stat_next;
  logic [rxps_pkg::NCH-1:0]      par_reg;
  logic [rxps_pkg::NCH-1:0]      par_next;
  logic [rxps_pkg::NCH-1:0]      evLoss;
  logic [rxps_pkg::NCH-1:0]      evViol;

  logic [1:0] parSel;
  logic       decEnable;
  logic [1:0] rx_mode_select;
  logic       wrFire;

  assign parSel    = ctrl_reg[rxps_pkg::CTRL_PAR_LSB +: 2];
  assign decEnable = ctrl_reg[rxps_pkg::CTRL_DEC_BIT];
  assign rx_mode_select    = ctrl_reg[rxps_pkg::CTRL_MODE_LSB +: 2];

  always_comb begin
    logic [2:0] st;
    logic [7:0] ch;
    logic       typeB;
    logic       cvHit;
    st        = rxps_pkg::ST_NORMAL;
    ch        = 8'h00;
    cvHit     = 1'b0;
    typeB     = rx_mode_select[0];
    sync_next = sync_reg;
    char_next = char_reg;
    stat_next = stat_reg;
    par_next  = par_reg;
    evLoss    = '0;
    evViol    = '0;
    for (int i = 0; i < rxps_pkg::NCH; i++) begin
      if (!rx_mode_select[1]) begin
        sync_next[i] = rxps_pkg::SYNC_NONE;
      end
      if (charStrobe[i]) begin
        cvHit = 1'b0;
        if (!decEnable) begin
          ch = rawChar[i][9:2];
          st = {framingHit[i], rawChar[i][0], rawChar[i][1]};
        end else if (!rx_mode_select[1]) begin
          ch = decChar[i];
          st = encStatus(pllUnlock[i], 1'b0, typeB, codeViol[i], framingHit[i],
                         rdErr[i], specialHit[i]);
          cvHit = codeViol[i] && !pllUnlock[i];
        end else begin
          ch = decChar[i];
          st = rxps_pkg::ST_LOSS_SYNC;
          unique case (sync_reg[i])
            rxps_pkg::SYNC_NONE: begin
              if (framingHit[i]) begin
                sync_next[i] = rxps_pkg::SYNC_REALIGN;
              end
            end
            rxps_pkg::SYNC_REALIGN: begin
              st = rxps_pkg::ST_FRAMING;
              if (typeB && codeViol[i]) begin
                st    = rxps_pkg::ST_CODE_VIOL;
                cvHit = 1'b1;
              end
              if (bitSyncLost[i]) begin
                sync_next[i] = rxps_pkg::SYNC_NONE;
              end else if (bondFail[i]) begin
                sync_next[i] = rxps_pkg::SYNC_BOND_FAIL;
              end else if (bondOk[i]) begin
                st           = rxps_pkg::ST_BUF_LOCK;
                sync_next[i] = rxps_pkg::SYNC_LOCKED;
              end
            end
            rxps_pkg::SYNC_BOND_FAIL: begin
              if (bitSyncLost[i]) begin
                sync_next[i] = rxps_pkg::SYNC_NONE;
              end else if (framingHit[i]) begin
                sync_next[i] = rxps_pkg::SYNC_REALIGN;
              end
            end
            rxps_pkg::SYNC_LOCKED: begin
              if (bitSyncLost[i] || pllUnlock[i]) begin
                evLoss[i]    = 1'b1;
                sync_next[i] = rxps_pkg::SYNC_NONE;
              end else begin
                st = encStatus(1'b0, bufErr[i], typeB, codeViol[i], framingHit[i],
                               rdErr[i], specialHit[i]);
                cvHit = codeViol[i];
              end
            end
          endcase
        end
        if (bistActive[i]) begin
          st    = bistStatus[i];
          cvHit = 1'b0;
        end
        evViol[i]    = cvHit;
        char_next[i] = ch;
        stat_next[i] = st;
        unique case (parSel)
          rxps_pkg::PAR_MID: begin
            par_next[i] = decEnable ? oddPar({3'h0, ch})
                                    : oddPar({1'b0, st[1:0], ch});
          end
          rxps_pkg::PAR_HIGH: begin
            par_next[i] = oddPar({st, ch});
          end
          default: begin
            par_next[i] = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < rxps_pkg::NCH; i++) begin
        sync_reg[i] <= rxps_pkg::SYNC_NONE;
      end
      char_reg <= '0;
      stat_reg <= '0;
      par_reg  <= '0;
    end else begin
      sync_reg <= sync_next;
      char_reg <= char_next;
      stat_reg <= stat_next;
      par_reg  <= par_next;
    end
  end

  assign rx_char_out   = char_reg;
  assign rx_status_out = stat_reg;
  assign rx_parity_out = par_reg;
  assign rxParityOeN   = {rxps_pkg::NCH{parSel != rxps_pkg::PAR_MID &&
                                        parSel != rxps_pkg::PAR_HIGH}};

  // AXI4-Lite slave and register file
  assign wrFire = awHeld_reg && wHeld_reg && !bValid_reg;

  always_comb begin
    logic [7:0] w1c;
    w1c          = 8'h00;
    ctrl_next    = ctrl_reg;
    intMask_next = intMask_reg;
    awHeld_next  = awHeld_reg;
    awAddr_next  = awAddr_reg;
    wHeld_next   = wHeld_reg;
    wData_next   = wData_reg;
    wStrb_next   = wStrb_reg;
    bValid_next  = bValid_reg;
    bResp_next   = bResp_reg;
    rValid_next  = rValid_reg;
    rData_next   = rData_reg;
    rResp_next   = rResp_reg;
    if (s_axi_awvalid && !awHeld_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (wrFire) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = rxps_pkg::RESP_OKAY;
      unique case (awAddr_reg)
        rxps_pkg::OFS_CTRL: begin
          if (wStrb_reg[0]) begin
            ctrl_next = wData_reg[4:0];
          end
        end
        rxps_pkg::OFS_INT_STATUS: begin
          if (wStrb_reg[0]) begin
            w1c = wData_reg[7:0];
          end
        end
        rxps_pkg::OFS_INT_MASK: begin
          if (wStrb_reg[0]) begin
            intMask_next = wData_reg[7:0];
          end
        end
        rxps_pkg::OFS_SYNC_STATE: begin
        end
        default: begin
          bResp_next = rxps_pkg::RESP_SLVERR;
        end
      endcase
    end else if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    // Set beats clear in the same cycle
    intStat_next = (intStat_reg & ~w1c) | {evViol, evLoss};
    if (s_axi_arvalid && !rValid_reg) begin
      rValid_next = 1'b1;
      rResp_next  = rxps_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rxps_pkg::OFS_CTRL: begin
          rData_next = {27'h0, ctrl_reg};
        end
        rxps_pkg::OFS_SYNC_STATE: begin
          rData_next = {24'h0, sync_reg};
        end
        rxps_pkg::OFS_INT_STATUS: begin
          rData_next = {24'h0, intStat_reg};
        end
        rxps_pkg::OFS_INT_MASK: begin
          rData_next = {24'h0, intMask_reg};
        end
        default: begin
          rData_next = 32'h0;
          rResp_next = rxps_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg    <= rxps_pkg::CTRL_RESET;
      intStat_reg <= 8'h00;
      intMask_reg <= rxps_pkg::INT_MASK_RESET;
      awHeld_reg  <= 1'b0;
      awAddr_reg  <= 8'h00;
      wHeld_reg   <= 1'b0;
      wData_reg   <= 32'h0;
      wStrb_reg   <= 4'h0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= 2'h0;
      rValid_reg  <= 1'b0;
      rData_reg   <= 32'h0;
      rResp_reg   <= 2'h0;
    end else begin
      ctrl_reg    <= ctrl_next;
      intStat_reg <= intStat_next;
      intMask_reg <= intMask_next;
      awHeld_reg  <= awHeld_next;
      awAddr_reg  <= awAddr_next;
      wHeld_reg   <= wHeld_next;
      wData_reg   <= wData_next;
      wStrb_reg   <= wStrb_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      rValid_reg  <= rValid_next;
      rData_reg   <= rData_next;
      rResp_reg   <= rResp_next;
    end
  end

  assign s_axi_awready = !awHeld_reg;
  assign s_axi_wready  = !wHeld_reg;
  assign s_axi_bvalid  = bValid_reg;
  assign s_axi_bresp   = bResp_reg;
  assign s_axi_arready = !rValid_reg;
  assign s_axi_rvalid  = rValid_reg;
  assign s_axi_rdata   = rData_reg;
  assign s_axi_rresp   = rResp_reg;
  assign irq           = |(intStat_reg & intMask_reg);

endmodule : rxps_top

/* hdl/rxps_pkg.sv */
// Constants, types and register map of the receive output parity and status block
// Notes on behaviour
// - Parity select low disables parity; every parity output is released (high impedance).
// - Parity select mid, decoder enabled: odd parity over the eight character bits.
// - Parity select mid, decoder bypassed: odd parity over character plus status bits one, zero.
// - Parity select high: odd parity over character and all three status bits.
// - Only odd parity; covered bits plus parity always hold a one.
// - Each channel has a parity output beside its eleven character and status outputs.
// - Decoder enabled: each character carries three status bits of validity, type, bonding.
// - Status bits report receive self-test state in either decoder mode.
// - Coinciding conditions report only the highest priority status code.
// - Bit zero of receive mode selects status reporting type A or B.
// - Bit one of receive mode high enables each channel's synchronisation machine while the decoder is enabled.
// - Bit one low: machines disabled, characters reported directly without sync status.
// - Type A machine: four states; only realign and locked emit more than one status type.
// - Type B machine: same four states; some emit one value, others several.
// - Decoder bypassed: top status bit is framing flag, rest carry raw ten-bit character.
package rxps_pkg;

  localparam int NCH = 4;

  // AXI4-Lite register map, byte addresses
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_SYNC_STATE = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_MASK   = 8'h0c;

  // Control register fields
  localparam int CTRL_PAR_LSB  = 0;
  localparam int CTRL_DEC_BIT  = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam logic [4:0] CTRL_RESET     = 5'h04;
  localparam logic [7:0] INT_MASK_RESET = 8'h00;
  localparam int INT_VIOL_LSB = 4;

  // Three-level parity select encodings
  localparam logic [1:0] PAR_LOW  = 2'h0;
  localparam logic [1:0] PAR_MID  = 2'h1;
  localparam logic [1:0] PAR_HIGH = 2'h2;

  // Receive status codes
  localparam logic [2:0] ST_NORMAL    = 3'h0;
  localparam logic [2:0] ST_SPECIAL   = 3'h1;
  localparam logic [2:0] ST_BUF_LOCK  = 3'h2;
  localparam logic [2:0] ST_FRAMING   = 3'h3;
  localparam logic [2:0] ST_CODE_VIOL = 3'h4;
  localparam logic [2:0] ST_LOSS_SYNC = 3'h5;
  localparam logic [2:0] ST_RD_ERR    = 3'h6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SYNC_NONE      = 2'b00,
    SYNC_REALIGN   = 2'b01,
    SYNC_BOND_FAIL = 2'b10,
    SYNC_LOCKED    = 2'b11
  } rxps_sync_t;

endpackage : rxps_pkg

/* verification/rxps_monitor.sv */
// Checker for the output bus, parity pins and register bus handshakes
`timescale 1ns/10ps
module rxps_monitor (
  input wire logic                          clk_sys,
  input wire logic                          nrst,
  input wire logic [rxps_pkg::NCH-1:0]      charStrobe,
  input wire logic [rxps_pkg::NCH-1:0][7:0] rx_char_out,
  input wire logic [rxps_pkg::NCH-1:0][2:0] rx_status_out,
  input wire logic [rxps_pkg::NCH-1:0]      rx_parity_out,
  input wire logic [rxps_pkg::NCH-1:0]      rxParityOeN,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_wvalid,
  input wire logic                          s_axi_wready,
  input wire logic [1:0]                    s_axi_bresp,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_bready,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic [31:0]                   s_axi_rdata,
  input wire logic                          s_axi_rvalid,
  input wire logic                          s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_oe_shared:
    assert property (rxParityOeN == '0 || rxParityOeN == '1)
    else $error("parity enables differ between channels");
  chk_odd_nonzero:
    assert property ((charStrobe[0] && !rxParityOeN[0]) ##1 !rxParityOeN[0]
      |-> |{rx_parity_out[0], rx_char_out[0], rx_status_out[0]})
    else $error("covered bits and parity all zero");
  chk_out_hold:
    assert property (!charStrobe[0] ##1 $stable(rxParityOeN[0]) |-> $stable(rx_char_out[0])
      && $stable(rx_status_out[0]) && $stable(rx_parity_out[0]))
    else $error("output register changed without a strobe");
  chk_reset_clear:
    assert property ($rose(nrst) |-> rx_char_out == '0 && rxParityOeN == '1 && !s_axi_bvalid)
    else $error("outputs not at reset values");
  chk_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_r_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_latency:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_ar_block:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule : rxps_monitor

bind rxps_top rxps_monitor u_rxps_monitor (
  .clk_sys, .nrst, .charStrobe, .rx_char_out, .rx_status_out, .rx_parity_out,
  .rxParityOeN, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

/* verification/rxps_host_model.sv */
// Host side model: resolves the parity pins seen by the receiving logic
`timescale 1ns/10ps
module rxps_host_model (
  input wire logic                     clk_sys,
  input wire logic [rxps_pkg::NCH-1:0] rxParityOeN,
  input wire logic [rxps_pkg::NCH-1:0] rx_parity_out,
  output logic     [rxps_pkg::NCH-1:0] parWire
);
  logic [rxps_pkg::NCH-1:0] lastReg;

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < rxps_pkg::NCH; i++) begin
      if (!rxParityOeN[i]) lastReg[i] <= rx_parity_out[i];
    end
  end
  // Released pin shows the inverse of the last driven level
  always_comb begin
    for (int i = 0; i < rxps_pkg::NCH; i++) begin
      parWire[i] = rxParityOeN[i] ? ~lastReg[i] : rx_parity_out[i];
    end
  end
endmodule : rxps_host_model

/* verification/rxps_top_tb.sv */
// Self-checking bench for the receive output parity and status block
`timescale 1ns/10ps
module rxps_top_tb;
  localparam int N = rxps_pkg::NCH;
  logic              clk_sys = 1'b0;
  logic              nrst = 1'b0;
  logic [N-1:0]      charStrobe = '0, framingHit = '0, specialHit = '0, codeViol = '0;
  logic [N-1:0]      rdErr = '0, bufErr = '0, pllUnlock = '0, bitSyncLost = '0;
  logic [N-1:0]      bondOk = '0, bondFail = '0, bistActive = '0;
  logic [N-1:0][7:0] decChar = '0;
  logic [N-1:0][9:0] rawChar = '0;
  logic [N-1:0][2:0] bistStatus = '0;
  logic [N-1:0][7:0] rx_char_out;
  logic [N-1:0][2:0] rx_status_out;
  logic [N-1:0]      rx_parity_out, rxParityOeN, parWire;
  logic              irq;
  logic [7:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                error_cnt = 0, n_checks = 0;
  logic [7:0]        fl [5] = '{8'h0c, 8'h14, 8'h09, 8'h0a, 8'h00};
  logic [2:0]        st [5] = '{3'h4, 3'h5, 3'h3, 3'h6, 3'h0};
  logic [7:0]        sf [8] = '{8'h00, 8'h01, 8'h00, 8'h40, 8'h02, 8'h20, 8'h01, 8'h04};
  logic [2:0]        ss [8] = '{3'h5, 3'h5, 3'h3, 3'h2, 3'h1, 3'h5, 3'h5, 3'h4};
  logic [9:0]        bf [5] = '{10'h200, 10'h000, 10'h001, 10'h040, 10'h100};
  logic [2:0]        bs [5] = '{3'h3, 3'h5, 3'h5, 3'h2, 3'h5};

  rxps_top u_rxps_top (
    .clk_sys, .nrst, .charStrobe, .decChar, .rawChar, .framingHit, .specialHit,
    .codeViol, .rdErr, .bufErr, .pllUnlock, .bitSyncLost, .bondOk, .bondFail,
    .bistActive, .bistStatus, .rx_char_out, .rx_status_out, .rx_parity_out,
    .rxParityOeN, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  rxps_host_model u_rxps_host_model (.clk_sys, .rxParityOeN, .rx_parity_out, .parWire);

  always #20 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(ha && hw)) begin
      @(posedge clk_sys);
      if (!ha && s_axi_awready) begin
        ha = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!hw && s_axi_wready) begin
        hw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask : rdc

  task automatic put(input logic [7:0] d, input logic [9:0] r, input logic [9:0] f);
    @(posedge clk_sys);
    charStrobe <= '1;
    decChar <= {N{d}};
    rawChar <= {N{r}};
    framingHit <= {N{f[0]}};
    specialHit <= {N{f[1]}};
    codeViol <= {N{f[2]}};
    rdErr <= {N{f[3]}};
    pllUnlock <= {N{f[4]}};
    bitSyncLost <= {N{f[5]}};
    bondOk <= {N{f[6]}};
    bistActive <= {N{f[7]}};
    bufErr <= {N{f[8]}};
    bondFail <= {N{f[9]}};
    @(posedge clk_sys);
    charStrobe <= '0;
    @(posedge clk_sys);
  endtask : put

  task automatic out(input logic [7:0] c, input logic [2:0] s, input logic p, input logic off);
    for (int i = 0; i < N; i++) begin
      chk(rx_char_out[i], c);
      chk(rx_status_out[i], s);
      chk(rxParityOeN[i], off);
      if (!off) chk(parWire[i], p);
    end
  endtask : out

  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    conclude();
  end

  initial begin
    logic [7:0] ec;
    logic [2:0] es;
    logic [1:0] p;
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rdc(rxps_pkg::OFS_CTRL, 32'h00000004, rxps_pkg::RESP_OKAY);
    rdc(rxps_pkg::OFS_INT_MASK, 32'h00000000, rxps_pkg::RESP_OKAY);
    rdc(8'h10, 32'h00000000, rxps_pkg::RESP_SLVERR);
    wr(8'h14, 32'h00000001, rxps_pkg::RESP_SLVERR);
    chk(rxParityOeN, 4'hf);
    wr(rxps_pkg::OFS_CTRL, 32'h00000007, rxps_pkg::RESP_OKAY);
    chk(rxParityOeN, 4'hf);
    $display("test reset done");
    for (int m = 0; m < 6; m++) begin
      p = 2'(m % 3);
      wr(rxps_pkg::OFS_CTRL, {m >= 3, p}, rxps_pkg::RESP_OKAY);
      put(8'h5a, 10'h2a5, 8'h03);
      ec = (m >= 3) ? 8'h5a : 8'ha9;
      es = (m >= 3) ? rxps_pkg::ST_FRAMING : 3'h6;
      out(ec, es, (p == 2'h1) ? ((m >= 3) ? ~^ec : ~^{es[1:0], ec}) : ~^{es, ec},
          p == 2'h0);
    end
    $display("test parity done");
    wr(rxps_pkg::OFS_CTRL, 32'h00000006, rxps_pkg::RESP_OKAY);
    for (int k = 0; k < 5; k++) begin
      put(8'h81, 10'h000, fl[k]);
      out(8'h81, st[k], ~^{st[k], 8'h81}, 1'b0);
    end
    $display("test priority done");
    rdc(rxps_pkg::OFS_INT_STATUS, 32'h000000f0, rxps_pkg::RESP_OKAY);
    chk(irq, 1'b0);
    wr(rxps_pkg::OFS_INT_MASK, 32'h00000010, rxps_pkg::RESP_OKAY);
    chk(irq, 1'b1);
    wr(rxps_pkg::OFS_INT_STATUS, 32'h000000f0, rxps_pkg::RESP_OKAY);
    chk(irq, 1'b0);
    $display("test interrupt done");
    wr(rxps_pkg::OFS_CTRL, 32'h00000016, rxps_pkg::RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      if (k == 6) begin
        rdc(rxps_pkg::OFS_INT_STATUS, 32'h0000000f, rxps_pkg::RESP_OKAY);
        chk(irq, 1'b0);
        wr(rxps_pkg::OFS_CTRL, 32'h0000001e, rxps_pkg::RESP_OKAY);
      end
      put(8'h3c, 10'h000, sf[k]);
      out(8'h3c, ss[k], ~^{ss[k], 8'h3c}, 1'b0);
      if (k == 3) rdc(rxps_pkg::OFS_SYNC_STATE, 32'h000000ff, rxps_pkg::RESP_OKAY);
    end
    chk(irq, 1'b1);
    for (int k = 0; k < 5; k++) begin
      put(8'h3c, 10'h000, bf[k]);
      out(8'h3c, bs[k], ~^{bs[k], 8'h3c}, 1'b0);
    end
    wr(rxps_pkg::OFS_CTRL, 32'h00000016, rxps_pkg::RESP_OKAY);
    put(8'h3c, 10'h000, 10'h100);
    out(8'h3c, rxps_pkg::ST_BUF_LOCK, ~^{rxps_pkg::ST_BUF_LOCK, 8'h3c}, 1'b0);
    $display("test sync done");
    wr(rxps_pkg::OFS_CTRL, 32'h00000006, rxps_pkg::RESP_OKAY);
    rdc(rxps_pkg::OFS_SYNC_STATE, 32'h00000000, rxps_pkg::RESP_OKAY);
    put(8'h3c, 10'h000, 8'h00);
    out(8'h3c, rxps_pkg::ST_NORMAL, ~^{3'h0, 8'h3c}, 1'b0);
    wr(rxps_pkg::OFS_CTRL, 32'h00000002, rxps_pkg::RESP_OKAY);
    bistStatus <= {N{3'h5}};
    put(8'h00, 10'h3fc, 8'h80);
    out(8'hff, 3'h5, ~^{3'h5, 8'hff}, 1'b0);
    $display("test self-test done");
    conclude();
  end
endmodule : rxps_top_tb
